// File: bench/sip_host_model.sv
`timescale 1ns/10ps
module sip_host_model (
    // Clock
    input wire logic clk_sys,
    // Serial pins
    output logic serial_select_n,
    output logic serial_clk,
    output logic serial_mosi
);
    initial
    begin
        serial_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_mosi = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Serial clock idles low outside frames; data is inverted once released
    task automatic send(input logic [15:0] f, input int n);
        wait_n(1);
        serial_select_n = 1'b0;
        wait_n(4);
        for (int i = 0; i < n; i++)
        begin
            serial_mosi = f[15 - (i % 16)];
            wait_n(4);
            serial_clk = 1'b1;
            wait_n(4);
            serial_clk = 1'b0;
        end
        wait_n(4);
        serial_select_n = 1'b1;
        serial_mosi = ~serial_mosi;
        wait_n(8);
    endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
    logic clk_sys;
    logic srst;
    logic init_phase;
    logic main_active;
    logic ext_pass_fitted;
    logic serial_select_n;
    logic serial_clk;
    logic serial_mosi;
    logic [39:0] ev;
    logic irq_pulse_n;
    logic [44:0] event_flags;
    logic bus_supply_enable;
    logic cfg_long_pulse;
    logic cfg_repeat;
    int fail_count = 0;
    int total_checks = 0;
    int w;

    sip_top #(.PULSE_SHORT_CYC(8), .PULSE_LONG_CYC(16)) dut_u (
        .clk_sys(clk_sys), .srst(srst), .init_phase(init_phase), .main_active(main_active),
        .ext_pass_fitted(ext_pass_fitted), .serial_select_n(serial_select_n),
        .serial_clk(serial_clk), .serial_mosi(serial_mosi),
        .rail_current_limit(ev[4:0]), .rail_overvoltage(ev[9:5]),
        .rail_undervoltage(ev[14:10]), .analog_reg_thermal_shutdown(ev[15]),
        .aux_reg_thermal_shutdown(ev[16]), .bus_supply_thermal_shutdown(ev[17]),
        .analog_limit_timeout(ev[18]), .aux_limit_timeout(ev[19]),
        .converter_run_mode(ev[20]), .prereg_active(ev[21]), .core_conv_active(ev[22]),
        .io_level(ev[28:23]), .pin_wakeup_event(ev[34:29]), .bus_wakeup_event(ev[35]),
        .txd_stuck_dominant(ev[36]), .rxd_stuck_recessive(ev[37]),
        .bus_stuck_dominant(ev[38]), .transceiver_overtemp(ev[39]),
        .irq_pulse_n(irq_pulse_n), .event_flags(event_flags),
        .bus_supply_enable(bus_supply_enable), .cfg_long_pulse(cfg_long_pulse),
        .cfg_repeat(cfg_repeat)
    );

    sip_host_model host_u (
        .clk_sys(clk_sys), .serial_select_n(serial_select_n),
        .serial_clk(serial_clk), .serial_mosi(serial_mosi)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] mk(input logic rw, input logic [4:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = {rw, a, d, ^a, 1'b0};
        f[0] = ~^f[15:1];
        return f;
    endfunction

    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input string nm, input logic [44:0] exp, input logic [44:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_n(input string nm, input int exp, input int got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // Waits up to lim cycles for the pin to fall, then counts its low cycles
    task automatic measure(input int lim, output int wid);
        int k;
        wid = 0;
        k = 0;
        while (irq_pulse_n !== 1'b0 && k < lim)
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        while (irq_pulse_n === 1'b0 && wid < 100)
        begin
            @(posedge clk_sys);
            #1;
            wid++;
        end
    endtask

    task automatic req_pulse(input logic [15:0] f, output int wid);
        fork
            host_u.send(f, 16);
            measure(400, wid);
        join
    endtask

    task automatic read_clear();
        for (int a = 0; a < 6; a++)
        begin
            host_u.send(mk(1'b0, sip_pkg::ADDR_FLAG_BASE + 5'(a), 8'h00), 16);
        end
        step(6);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge clk_sys);
        fail_count++;
        test_done();
    end

    initial
    begin
        srst = 1'b1;
        init_phase = 1'b1;
        main_active = 1'b0;
        ext_pass_fitted = 1'b1;
        ev = 40'h0;
        step(20);
        srst = 1'b0;
        step(2);
        chk("irq_idle", 45'h1, irq_pulse_n);
        chk("flags_rst", 45'h0, event_flags);
        chk("supply_rst", 45'h1, bus_supply_enable);
        chk("cfg_rst", 45'h0, {cfg_repeat, cfg_long_pulse});
        $display("test reset done");
        // Rows: input bit i sets flag i; flags accumulate
        for (int i = 0; i < 40; i++)
        begin
            ev[i] = 1'b1;
            step(6);
            chk("row", (45'h2 << i) - 1'b1, event_flags);
            if (i == 17)
                chk("supply_off", 45'h0, bus_supply_enable);
        end
        ev = 40'h0;
        step(6);
        read_clear();
        chk("flags_clear", 45'h0, event_flags);
        chk("supply_back", 45'h1, bus_supply_enable);
        step(700);
        chk("irq_settled", 45'h1, irq_pulse_n);
        $display("test events done");
        req_pulse(mk(1'b1, sip_pkg::ADDR_REQ, 8'h01), w);
        chk_n("short_width", 8, w);
        chk("req_flag", 45'h1, event_flags[sip_pkg::EV_INT_REQ]);
        host_u.send(mk(1'b1, sip_pkg::ADDR_CFG, 8'h01), 16);
        step(300);
        chk("cfg_long", 45'h1, cfg_long_pulse);
        req_pulse(mk(1'b1, sip_pkg::ADDR_REQ, 8'h01), w);
        chk_n("long_width", 16, w);
        host_u.send(mk(1'b1, sip_pkg::ADDR_CFG, 8'h00), 16);
        step(300);
        $display("test pulse done");
        host_u.send(mk(1'b1, sip_pkg::ADDR_MASK_BASE, 8'h01), 16);
        step(300);
        ev[0] = 1'b1;
        measure(300, w);
        chk_n("masked_pulse", 0, w);
        chk("masked_flag", 45'h1, event_flags[0]);
        $display("test mask done");
        req_pulse(mk(1'b1, sip_pkg::ADDR_CFG, 8'h02), w);
        chk_n("repeat_first", 8, w);
        chk("cfg_repeat", 45'h1, cfg_repeat);
        measure(400, w);
        chk_n("repeat_again", 8, w);
        host_u.send(mk(1'b1, sip_pkg::ADDR_CFG, 8'h00), 16);
        step(300);
        $display("test repeat done");
        init_phase = 1'b0;
        host_u.send(mk(1'b1, sip_pkg::ADDR_CFG, 8'h01), 16);
        step(6);
        chk("init_only", 45'h1, event_flags[sip_pkg::EV_ACCESS]);
        chk("cfg_kept", 45'h0, cfg_long_pulse);
        host_u.send(mk(1'b0, sip_pkg::ADDR_FLAG_BASE + 5'h05, 8'h00), 16);
        chk("acc_clear", 45'h0, event_flags[sip_pkg::EV_ACCESS]);
        host_u.send(mk(1'b0, 5'h1F, 8'h00), 16);
        step(6);
        chk("bad_addr", 45'h1, event_flags[sip_pkg::EV_ACCESS]);
        main_active = 1'b1;
        host_u.send(mk(1'b1, sip_pkg::ADDR_REQ, 8'h01), 15);
        step(6);
        chk("clk_count", 45'h1, event_flags[sip_pkg::EV_CLK_CNT]);
        host_u.send(mk(1'b1, sip_pkg::ADDR_REQ, 8'h01) ^ 16'h0001, 16);
        step(6);
        chk("parity", 45'h1, event_flags[sip_pkg::EV_PARITY]);
        host_u.send(mk(1'b1, sip_pkg::ADDR_REQ, 8'h01) ^ 16'h0003, 16);
        step(6);
        chk("secure", 45'h1, event_flags[sip_pkg::EV_SEC]);
        ext_pass_fitted = 1'b0;
        ev[18] = 1'b1;
        step(6);
        chk("no_pass_dev", 45'h0, event_flags[sip_pkg::EV_LTO_CCA]);
        $display("test errors done");
        test_done();
    end
endmodule

// File: logic/sip_pkg.sv
package sip_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_SHORT_NS = 25000;
    localparam int PULSE_LONG_NS = 100000;
    localparam int PULSE_GAP_NS = 1000;
    localparam int PULSE_SHORT_CYC = (PULSE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_LONG_CYC = (PULSE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_GAP_CYC = (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // Event vector layout
    localparam int RAIL_N = 5;
    localparam int IO_N = 6;
    localparam int EV_LIM_BASE = 0;
    localparam int EV_OV_BASE = 5;
    localparam int EV_UV_BASE = 10;
    localparam int EV_TSD_CCA = 15;
    localparam int EV_TSD_AUX = 16;
    localparam int EV_TSD_CAN = 17;
    localparam int EV_LTO_CCA = 18;
    localparam int EV_LTO_AUX = 19;
    localparam int EV_RUN_MODE = 20;
    localparam int EV_PRE_ACT = 21;
    localparam int EV_CORE_ACT = 22;
    localparam int EV_IO_BASE = 23;
    localparam int EV_WU_BASE = 29;
    localparam int EV_BUS_WU = 35;
    localparam int EV_TXD_DOM = 36;
    localparam int EV_RXD_REC = 37;
    localparam int EV_BUS_DOM = 38;
    localparam int EV_XCV_OT = 39;
    localparam int PIN_EVT_W = 40;
    localparam int EV_INT_REQ = 40;
    localparam int EV_SEC = 41;
    localparam int EV_CLK_CNT = 42;
    localparam int EV_ACCESS = 43;
    localparam int EV_PARITY = 44;
    localparam int EVT_W = 45;

    // Serial frame layout
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] BITCNT_MAX = 5'h1F;
    localparam int FRM_RW_BIT = 15;
    localparam int FRM_ADDR_LSB = 10;
    localparam int FRM_DATA_LSB = 2;
    localparam int FRM_SEC_BIT = 1;
    localparam int ADDR_W = 5;
    localparam int CHUNK_W = 8;
    localparam int CHUNK_N = 6;

    // Register addresses
    localparam logic [4:0] ADDR_CFG = 5'h01;
    localparam logic [4:0] ADDR_MASK_BASE = 5'h08;
    localparam logic [4:0] ADDR_FLAG_BASE = 5'h10;
    localparam logic [4:0] ADDR_REQ = 5'h18;
    localparam logic [4:0] ADDR_CHUNKS = 5'h06;

    // Configuration fields and reset values
    localparam int CFG_LONG_BIT = 0;
    localparam int CFG_REPEAT_BIT = 1;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [44:0] MASK_RST = 45'h0;
    localparam logic [44:0] FLAG_RST = 45'h0;
    localparam logic [15:0] SHIFT_RST = 16'h0;
endpackage

// File: logic/sip_pulse_gen.sv
`timescale 1ns/10ps
module sip_pulse_gen #(
    parameter int SHORT_CYC = 1,
    parameter int LONG_CYC = 1,
    parameter int GAP_CYC = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Request side
    sip_pulse_if.gen pls,
    // Pin
    output logic irq_pulse_n
);
    typedef enum logic [1:0] {SIP_IDLE, SIP_LOW, SIP_GAP} sip_pulse_state_e;

    sip_pulse_state_e state_q, state_d;
    logic [sip_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [sip_pkg::CNT_W-1:0] width_q, width_d;
    logic pend_q, pend_d;
    logic irq_d;
    logic [sip_pkg::CNT_W-1:0] low_run_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        width_d = width_q;
        pend_d = pend_q;
        unique case (state_q)
            SIP_IDLE:
            begin
                if (pls.fire || pend_q)
                begin
                    // Width chosen at start of each pulse from the init setting [R2]
                    width_d = pls.long_sel ? sip_pkg::CNT_W'(LONG_CYC)
                                           : sip_pkg::CNT_W'(SHORT_CYC);
                    cnt_d = width_d - 1'b1;
                    state_d = SIP_LOW;
                    pend_d = 1'b0;
                end
            end
            SIP_LOW:
            begin
                pend_d = pend_q | pls.fire; // [R17]
                if (cnt_q == '0)
                begin
                    state_d = SIP_GAP;
                    cnt_d = sip_pkg::CNT_W'(GAP_CYC - 1);
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            SIP_GAP:
            begin
                pend_d = pend_q | pls.fire;
                if (cnt_q == '0)
                begin
                    state_d = SIP_IDLE;
                end
                else
                begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
        irq_d = (state_d != SIP_LOW); // [R1]
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_q <= SIP_IDLE;
            cnt_q <= '0;
            width_q <= sip_pkg::CNT_W'(SHORT_CYC);
            pend_q <= 1'b0;
            irq_pulse_n <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            width_q <= width_d;
            pend_q <= pend_d;
            irq_pulse_n <= irq_d;
        end
    end

    assign pls.busy = (state_q != SIP_IDLE);

    // Length of the current low phase, for checking only
    always_ff @(posedge clk_sys)
    begin
        if (srst || irq_pulse_n)
        begin
            low_run_q <= '0;
        end
        else
        begin
            low_run_q <= low_run_q + 1'b1;
        end
    end

    property p_pulse_width;
        @(posedge clk_sys) disable iff (srst)
        $rose(irq_pulse_n) |-> $past(low_run_q) == width_q - 1'b1;
    endproperty
    a_pulse_width: assert property (p_pulse_width) // [R2]
        else $error("interrupt pulse width differs from setting");

    property p_fire_starts;
        @(posedge clk_sys) disable iff (srst)
        (pls.fire && state_q == SIP_IDLE) |=> !irq_pulse_n;
    endproperty
    a_fire_starts: assert property (p_fire_starts) // [R1]
        else $error("request did not pull interrupt low");

    property p_release_gap;
        @(posedge clk_sys) disable iff (srst)
        $rose(irq_pulse_n) |-> irq_pulse_n[*2];
    endproperty
    a_release_gap: assert property (p_release_gap) // [R1]
        else $error("interrupt not released high between pulses");

    property p_pending_kept;
        @(posedge clk_sys) disable iff (srst)
        (pls.fire && pls.busy) |=> pend_q;
    endproperty
    a_pending_kept: assert property (p_pending_kept) // [R17]
        else $error("request during pulse was lost");
endmodule

// File: logic/sip_pulse_if.sv
`timescale 1ns/10ps
interface sip_pulse_if;
    logic fire;
    logic long_sel;
    logic busy;
    modport src (output fire, output long_sel, input busy);
    modport gen (input fire, input long_sel, output busy);
endinterface

// File: logic/sip_sync_edge.sv
`timescale 1ns/10ps
module sip_sync_edge #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Pins and results
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule

// File: logic/sip_top.sv
`timescale 1ns/10ps
// Overview of operation
// R1 - Any unmasked event pulls the interrupt pin low for one pulse, then high.
// R2 - Host sets pulse behaviour and width in init; every later pulse uses them.
// R3 - Per-source mask bits stop chosen sources from producing pulses; a host request still pulses with its mask bit set.
// R4 - Thermal shutdown, current limit, over and undervoltage of the rails raise events.
// R5 - With external pass device, current-limit timeout raises an event.
// R6 - Converter run mode and both converter enable states are reported as events.
// R7 - Each of six I/O pins raises an event on every level change.
// R8 - Each of six I/O pins has its own wake-up event.
// R9 - A bus wake-up raises an event.
// R10 - Stuck transmit, stuck receive, stuck bus and transceiver overheat are distinct events.
// R11 - Bus supply thermal shutdown raises an event; supply restarts once cooled.
// R12 - Host request over the serial link produces one interrupt pulse.
// R13 - In main state, a frame without exactly 16 clocks is an error.
// R14 - Malformed access, unknown address or init-only write in normal mode is an error.
// R15 - In main state, a frame parity mismatch is an error.
// R16 - Each frame's secured check bit is verified; failure is an error. The code checks it only in frames with 16 clocks and correct parity.
// R17 - Events stay flagged until the host reads them; none lost during a pulse.
module sip_top #(
    parameter int PULSE_SHORT_CYC = sip_pkg::PULSE_SHORT_CYC,
    parameter int PULSE_LONG_CYC = sip_pkg::PULSE_LONG_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Device state
    input wire logic init_phase,
    input wire logic main_active,
    input wire logic ext_pass_fitted,
    // Serial link pins
    input wire logic serial_select_n,
    input wire logic serial_clk,
    input wire logic serial_mosi,
    // Supply monitors
    input wire logic [4:0] rail_current_limit,
    input wire logic [4:0] rail_overvoltage,
    input wire logic [4:0] rail_undervoltage,
    input wire logic analog_reg_thermal_shutdown,
    input wire logic aux_reg_thermal_shutdown,
    input wire logic bus_supply_thermal_shutdown,
    input wire logic analog_limit_timeout,
    input wire logic aux_limit_timeout,
    input wire logic converter_run_mode,
    input wire logic prereg_active,
    input wire logic core_conv_active,
    // I/O pins and transceiver
    input wire logic [5:0] io_level,
    input wire logic [5:0] pin_wakeup_event,
    input wire logic bus_wakeup_event,
    input wire logic txd_stuck_dominant,
    input wire logic rxd_stuck_recessive,
    input wire logic bus_stuck_dominant,
    input wire logic transceiver_overtemp,
    // Outputs
    output logic irq_pulse_n,
    output logic [44:0] event_flags,
    output logic bus_supply_enable,
    output logic cfg_long_pulse,
    output logic cfg_repeat
);
    logic [sip_pkg::PIN_EVT_W-1:0] raw_pins, pin_lvl, pin_rise, pin_fall, pin_evt;
    logic [2:0] ser_lvl, ser_rise, ser_fall;
    logic [sip_pkg::EVT_W-1:0] evt_set, flag_q, flag_d, mask_q, mask_d, clr_vec, wsel_vec;
    logic [sip_pkg::EVT_W-1:0] wdat_vec;
    logic [15:0] shift_q, shift_d;
    logic [4:0] bitcnt_q, bitcnt_d;
    logic [1:0] cfg_q, cfg_d;
    logic supply_en_q, supply_en_d;
    logic frame_end, cnt_ok, par_ok, sec_ok, good;
    logic rw;
    logic [sip_pkg::ADDR_W-1:0] addr, mask_off, flag_off;
    logic [sip_pkg::CHUNK_W-1:0] wdata;
    logic is_cfg, is_mask, is_flag, is_req, acc_err, wr_init;
    logic req_evt, sec_evt, clk_evt, par_evt;

    sip_pulse_if pls ();

    assign raw_pins = {transceiver_overtemp, bus_stuck_dominant, rxd_stuck_recessive,
                       txd_stuck_dominant, bus_wakeup_event, pin_wakeup_event, io_level,
                       core_conv_active, prereg_active, converter_run_mode,
                       aux_limit_timeout, analog_limit_timeout,
                       bus_supply_thermal_shutdown, aux_reg_thermal_shutdown,
                       analog_reg_thermal_shutdown, rail_undervoltage, rail_overvoltage,
                       rail_current_limit};

    sip_sync_edge #(.W(sip_pkg::PIN_EVT_W)) u_pin_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(raw_pins),
        .lvl(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    sip_sync_edge #(.W(3)) u_ser_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in({serial_mosi, serial_clk, serial_select_n}),
        .lvl(ser_lvl),
        .rise(ser_rise),
        .fall(ser_fall)
    );

    // Pin sourced events: status and I/O sources fire on both edges
    always_comb
    begin
        pin_evt = pin_rise; // [R4] [R8] [R9] [R10]
        pin_evt[sip_pkg::EV_RUN_MODE +: 3] = pin_rise[sip_pkg::EV_RUN_MODE +: 3]
                                           | pin_fall[sip_pkg::EV_RUN_MODE +: 3]; // [R6]
        pin_evt[sip_pkg::EV_IO_BASE +: sip_pkg::IO_N] =
            pin_rise[sip_pkg::EV_IO_BASE +: sip_pkg::IO_N]
            | pin_fall[sip_pkg::EV_IO_BASE +: sip_pkg::IO_N]; // [R7]
        pin_evt[sip_pkg::EV_LTO_CCA] = pin_rise[sip_pkg::EV_LTO_CCA] & ext_pass_fitted; // [R5]
        pin_evt[sip_pkg::EV_LTO_AUX] = pin_rise[sip_pkg::EV_LTO_AUX] & ext_pass_fitted; // [R5]
    end

    // Frame decode at deselect
    assign frame_end = ser_rise[0];
    assign cnt_ok = (bitcnt_q == sip_pkg::FRAME_BITS);
    assign par_ok = ^shift_q; // odd parity over the whole frame
    assign sec_ok = shift_q[sip_pkg::FRM_SEC_BIT]
                    == ^shift_q[sip_pkg::FRM_ADDR_LSB +: sip_pkg::ADDR_W];
    assign good = frame_end && cnt_ok && par_ok && sec_ok;
    assign rw = shift_q[sip_pkg::FRM_RW_BIT];
    assign addr = shift_q[sip_pkg::FRM_ADDR_LSB +: sip_pkg::ADDR_W];
    assign wdata = shift_q[sip_pkg::FRM_DATA_LSB +: sip_pkg::CHUNK_W];
    assign mask_off = addr - sip_pkg::ADDR_MASK_BASE;
    assign flag_off = addr - sip_pkg::ADDR_FLAG_BASE;
    assign is_cfg = (addr == sip_pkg::ADDR_CFG);
    assign is_mask = (addr >= sip_pkg::ADDR_MASK_BASE) && (mask_off < sip_pkg::ADDR_CHUNKS);
    assign is_flag = (addr >= sip_pkg::ADDR_FLAG_BASE) && (flag_off < sip_pkg::ADDR_CHUNKS);
    assign is_req = (addr == sip_pkg::ADDR_REQ);
    assign wr_init = rw && (is_cfg || is_mask) && !init_phase;
    assign acc_err = !(is_cfg || is_mask || is_flag || is_req) // [R14]
                     || (rw && is_flag) || (!rw && is_req) || wr_init;

    assign clk_evt = frame_end && main_active && !cnt_ok; // [R13]
    assign par_evt = frame_end && main_active && cnt_ok && !par_ok; // [R15]
    assign sec_evt = frame_end && cnt_ok && par_ok && !sec_ok; // [R16]
    assign req_evt = good && !acc_err && rw && is_req && wdata[0]; // [R12]

    assign evt_set = {par_evt, good && acc_err, clk_evt, sec_evt, req_evt, pin_evt};

    // Per-bit clear and write selects
    genvar k;
    generate
        for (k = 0; k < sip_pkg::EVT_W; k++)
        begin : g_bit
            assign clr_vec[k] = good && !acc_err && !rw && is_flag
                                && (flag_off == sip_pkg::ADDR_W'(k / sip_pkg::CHUNK_W));
            assign wsel_vec[k] = good && !acc_err && rw && is_mask
                                 && (mask_off == sip_pkg::ADDR_W'(k / sip_pkg::CHUNK_W));
            assign wdat_vec[k] = wdata[k % sip_pkg::CHUNK_W];
        end
    endgenerate

    // Serial capture, flags, masks, configuration
    always_comb
    begin
        shift_d = shift_q;
        bitcnt_d = bitcnt_q;
        if (ser_fall[0])
        begin
            bitcnt_d = '0;
        end
        else if (!ser_lvl[0] && ser_rise[1])
        begin
            shift_d = {shift_q[14:0], ser_lvl[2]};
            if (bitcnt_q != sip_pkg::BITCNT_MAX)
            begin
                bitcnt_d = bitcnt_q + 1'b1;
            end
        end
        flag_d = (flag_q & ~clr_vec) | evt_set; // [R17]
        mask_d = (mask_q & ~wsel_vec) | (wdat_vec & wsel_vec); // [R3]
        cfg_d = cfg_q;
        if (good && !acc_err && rw && is_cfg)
        begin
            cfg_d = wdata[1:0]; // [R2]
        end
        supply_en_d = !pin_lvl[sip_pkg::EV_TSD_CAN]; // [R11]
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            shift_q <= sip_pkg::SHIFT_RST;
            bitcnt_q <= '0;
            flag_q <= sip_pkg::FLAG_RST;
            mask_q <= sip_pkg::MASK_RST;
            cfg_q <= sip_pkg::CFG_RST;
            supply_en_q <= 1'b1;
        end
        else
        begin
            shift_q <= shift_d;
            bitcnt_q <= bitcnt_d;
            flag_q <= flag_d;
            mask_q <= mask_d;
            cfg_q <= cfg_d;
            supply_en_q <= supply_en_d;
        end
    end

    // Pulse requests
    assign pls.fire = (|(evt_set & ~mask_q)) || req_evt // [R1] [R3] [R12]
                      || (cfg_q[sip_pkg::CFG_REPEAT_BIT] && |(flag_q & ~mask_q)
                          && !pls.busy);
    assign pls.long_sel = cfg_q[sip_pkg::CFG_LONG_BIT];

    sip_pulse_gen #(
        .SHORT_CYC(PULSE_SHORT_CYC),
        .LONG_CYC(PULSE_LONG_CYC),
        .GAP_CYC(sip_pkg::PULSE_GAP_CYC)
    ) u_pulse (
        .clk_sys(clk_sys),
        .srst(srst),
        .pls(pls),
        .irq_pulse_n(irq_pulse_n)
    );

    assign event_flags = flag_q;
    assign bus_supply_enable = supply_en_q;
    assign cfg_long_pulse = cfg_q[sip_pkg::CFG_LONG_BIT];
    assign cfg_repeat = cfg_q[sip_pkg::CFG_REPEAT_BIT];

    property p_masked_silent;
        @(posedge clk_sys) disable iff (srst)
        (!(|(evt_set & ~mask_q)) && !req_evt && !cfg_q[sip_pkg::CFG_REPEAT_BIT])
            |-> !pls.fire;
    endproperty
    a_masked_silent: assert property (p_masked_silent) // [R3]
        else $error("masked event produced a pulse request");

    property p_flag_held;
        @(posedge clk_sys) disable iff (srst)
        (|evt_set) |=> ((flag_q & $past(evt_set)) == $past(evt_set));
    endproperty
    a_flag_held: assert property (p_flag_held) // [R17]
        else $error("event flag not latched");

    property p_clk_count;
        @(posedge clk_sys) disable iff (srst)
        (frame_end && main_active && bitcnt_q != sip_pkg::FRAME_BITS)
            |=> flag_q[sip_pkg::EV_CLK_CNT];
    endproperty
    a_clk_count: assert property (p_clk_count) // [R13]
        else $error("wrong clock count not flagged");

    property p_parity;
        @(posedge clk_sys) disable iff (srst)
        (frame_end && main_active && cnt_ok && !(^shift_q)) |=> flag_q[sip_pkg::EV_PARITY];
    endproperty
    a_parity: assert property (p_parity) // [R15]
        else $error("parity error not flagged");

    property p_init_lock;
        @(posedge clk_sys) disable iff (srst)
        (good && rw && is_cfg && !init_phase)
            |=> $stable(cfg_q) && flag_q[sip_pkg::EV_ACCESS];
    endproperty
    a_init_lock: assert property (p_init_lock) // [R14]
        else $error("init-only write accepted in normal mode");

    property p_secure;
        @(posedge clk_sys) disable iff (srst)
        (frame_end && cnt_ok && par_ok && !sec_ok) |=> flag_q[sip_pkg::EV_SEC] ##1 $stable(mask_q);
    endproperty
    a_secure: assert property (p_secure) // [R16]
        else $error("secured check failure not flagged");

    property p_io_change;
        @(posedge clk_sys) disable iff (srst)
        $changed(pin_lvl[sip_pkg::EV_IO_BASE +: sip_pkg::IO_N]) |=> flag_q[sip_pkg::EV_IO_BASE +:
            sip_pkg::IO_N] != '0;
    endproperty
    a_io_change: assert property (p_io_change) // [R7]
        else $error("I/O level change not flagged");

    property p_request_pulse;
        @(posedge clk_sys) disable iff (srst)
        (req_evt && !pls.busy) |-> pls.fire ##1 !irq_pulse_n;
    endproperty
    a_request_pulse: assert property (p_request_pulse) // [R12]
        else $error("host request did not start a pulse");

    property p_pass_gate;
        @(posedge clk_sys) disable iff (srst)
        (pin_rise[sip_pkg::EV_LTO_CCA] && !ext_pass_fitted && !flag_q[sip_pkg::EV_LTO_CCA])
            |=> !flag_q[sip_pkg::EV_LTO_CCA];
    endproperty
    a_pass_gate: assert property (p_pass_gate) // [R5]
        else $error("limit timeout flagged without external pass device");

    property p_supply_off;
        @(posedge clk_sys) disable iff (srst)
        pin_lvl[sip_pkg::EV_TSD_CAN] |=> !bus_supply_enable;
    endproperty
    a_supply_off: assert property (p_supply_off) // [R11]
        else $error("bus supply not switched off on thermal shutdown");
endmodule
